/* File: drps_pkg.sv */
// drps_pkg: constants, types and state layout of the dual regulator power sequencer
// assumes a free-running 40 MHz clock and a single active-low reset
//
// What this block does
// - single-enable variant: common enable low shuts both regulators off
// - single-enable: enable rise turns first on now, second after 128 us
// - first output at 87 percent starts 200 ms timer, then power ok rises
// - dual-enable: primary enable drives first, secondary enable drives second
// - dual-enable: second on only while both enables high
// - dual-enable: second follows its enable directly, no start-up timer
// - first out of regulation drops power ok; with power ok present also second until power ok returns
// - supply low lockout disables both regulators and holds power ok low
// - lockout clear restores previous states if primary enable stayed high
// - power-up inside lockout keeps regulators off and power ok low
// - overheat turns both regulators off and holds power ok low
// - overheat clear restores states, power ok after fresh 200 ms delay
// - short on first regulator disables second until the short clears
package drps_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SEQ_DELAY_US = 128;
  localparam int unsigned PWR_OK_DELAY_MS = 200;
  localparam int unsigned SEQ_DELAY_CYC = SEQ_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PWR_OK_DELAY_CYC = PWR_OK_DELAY_MS * (CLK_HZ / 1_000);
  localparam int CNT_W = 24;

  typedef struct packed {
    logic primary_enable;
    logic secondary_enable_in;
    logic first_in_reg;
    logic first_short;
    logic supply_low_lockout;
    logic overheat_flag;
  } drps_in_t;

  typedef struct packed {
    drps_in_t s1;
    drps_in_t s2;
    logic pok_lost;
    logic seq_done;
    logic [CNT_W-1:0] seq_cnt;
    logic [CNT_W-1:0] pok_cnt;
    logic power_ok;
    logic first_on;
    logic second_on;
  } drps_state_t;
endpackage : drps_pkg

/* File: drps_top.sv */
// drps_top: digital control of two regulator enables and the power ok output
// assumes asynchronous pins from comparators and enables, one free-running clock
`timescale 1ns/1ps
`default_nettype none
module drps_top import drps_pkg::*; #(
  parameter int unsigned SEQ_CYC = SEQ_DELAY_CYC,
  parameter int unsigned POK_CYC = PWR_OK_DELAY_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cfg_dual_enable,
  input wire logic cfg_power_ok_present,
  input wire drps_in_t pins_in,
  output logic regulator_first,
  output logic regulator_second,
  output logic power_ok_out
);
  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_a1_q;
  logic rst_a2_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a1_q <= 1'b0;
      rst_a2_q <= 1'b0;
    end else begin
      rst_a1_q <= 1'b1;
      rst_a2_q <= rst_a1_q;
    end
  end
  wire rst_n = rst_a2_q;

  ////////////////////////////////////////////////////////////////////////
  // state
  drps_state_t st_q;
  drps_state_t st_d;
  logic fault;
  logic a_req;
  logic b_req;
  logic [CNT_W-1:0] seq_lim;
  logic [CNT_W-1:0] pok_lim;
  assign seq_lim = CNT_W'(SEQ_CYC);
  assign pok_lim = CNT_W'(POK_CYC);

  always_comb begin
    st_d = st_q;
    st_d.s1 = pins_in;
    st_d.s2 = st_q.s1;
    // lockout and overheat gate everything; enables are remembered so states return
    fault = st_q.s2.supply_low_lockout | st_q.s2.overheat_flag;
    a_req = st_q.s2.primary_enable & ~fault;
    // sequencing timer runs in both variants, used only in single-enable variant
    if (!a_req) begin
      st_d.seq_cnt = '0;
      st_d.seq_done = 1'b0;
    end else if (!st_q.seq_done) begin
      if (st_q.seq_cnt >= seq_lim - CNT_W'(1)) st_d.seq_done = 1'b1;
      else st_d.seq_cnt = st_q.seq_cnt + CNT_W'(1);
    end
    if (cfg_dual_enable) b_req = a_req & st_q.s2.secondary_enable_in;
    else b_req = a_req & st_q.seq_done;
    // power ok delay from first regulator in regulation
    if (!a_req || !st_q.s2.first_in_reg) begin
      st_d.pok_cnt = '0;
      st_d.power_ok = 1'b0;
    end else if (!st_q.power_ok) begin
      if (st_q.pok_cnt >= pok_lim - CNT_W'(1)) st_d.power_ok = 1'b1;
      else st_d.pok_cnt = st_q.pok_cnt + CNT_W'(1);
    end
    // with power ok present, regulation loss after power ok holds second off until power ok returns
    if (!a_req || st_d.power_ok) st_d.pok_lost = 1'b0;
    if (a_req && st_q.power_ok && !st_q.s2.first_in_reg) st_d.pok_lost = 1'b1;
    if (cfg_power_ok_present && st_q.pok_lost) b_req = 1'b0;
    if (st_q.s2.first_short) b_req = 1'b0;
    st_d.first_on = a_req;
    st_d.second_on = b_req;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) st_q <= '0;
    else st_q <= st_d;
  end

  assign regulator_first = st_q.first_on;
  assign regulator_second = st_q.second_on;
  assign power_ok_out = st_q.power_ok & cfg_power_ok_present;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence fault_seen;
    st_q.s2.supply_low_lockout || st_q.s2.overheat_flag;
  endsequence
  fault_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_seen |=> !regulator_first && !regulator_second && !st_q.power_ok)
    else $error("fault did not shut regulators");
  enable_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_q.s2.primary_enable |=> !regulator_first && !regulator_second)
    else $error("enable low left a regulator on");
  dual_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_dual_enable && regulator_second |-> $past(st_q.s2.secondary_enable_in))
    else $error("second on without its enable");
  short_b_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q.s2.first_short |=> !regulator_second)
    else $error("second on during short");
  seq_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_dual_enable && $rose(regulator_first) |=> !regulator_second [*8])
    else $error("second came on too early");
  pok_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(st_q.power_ok) |-> st_q.pok_cnt == pok_lim - CNT_W'(1))
    else $error("power ok rose before delay");
  pok_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_q.s2.first_in_reg |=> !st_q.power_ok)
    else $error("power ok held out of regulation");
  pok_lost_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_power_ok_present && st_q.pok_lost |=> !regulator_second)
    else $error("second on after regulation loss");
  heat_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q.s2.overheat_flag |=> !regulator_first)
    else $error("first on during overheat");
endmodule : drps_top
`default_nettype wire

/* File: drps_analog.sv */
// drps_analog: first regulator output and its 87 percent comparator
// assumes regulator_first from the design, one clock
`timescale 1ns/1ps
`default_nettype none
module drps_analog (
  input wire logic mclk,
  input wire logic regulator_first,
  output logic first_in_reg
);
  logic [2:0] ramp_q;
  // output ramps for three cycles, drops at once when disabled
  always_ff @(posedge mclk) ramp_q <= {ramp_q[1:0], regulator_first};
  assign first_in_reg = ramp_q[2] & regulator_first;
endmodule : drps_analog
`default_nettype wire

/* File: test_drps_top.sv */
// test_drps_top: sequence tests of the power sequencer
// assumes drps_top, drps_analog and drps_pkg compiled before
`timescale 1ns/1ps
`default_nettype none
module test_drps_top;
  import drps_pkg::*;
  logic mclk = 0, reset_n = 0, cfg_dual_enable = 0, cfg_power_ok_present = 1;
  logic first_in_reg, regulator_first, regulator_second, power_ok_out;
  drps_in_t drv = '0, pins_in;
  logic sag = 0;
  int num_errors = 0, cmp_count = 0;
  localparam drps_in_t P = 6'h20, S = 6'h10, SH = 6'h04, LO = 6'h02, OT = 6'h01;
  always #12.5 mclk = ~mclk;
  always_comb begin
    pins_in = drv;
    pins_in.first_in_reg = first_in_reg & ~sag;
  end
  drps_top #(.SEQ_CYC(16), .POK_CYC(40)) u_drps_top (.mclk(mclk), .reset_n(reset_n),
    .cfg_dual_enable(cfg_dual_enable), .cfg_power_ok_present(cfg_power_ok_present),
    .pins_in(pins_in), .regulator_first(regulator_first),
    .regulator_second(regulator_second), .power_ok_out(power_ok_out));
  drps_analog u_drps_analog (.mclk(mclk), .regulator_first(regulator_first),
    .first_in_reg(first_in_reg));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic put(input drps_in_t v);
    @(posedge mclk);
    drv <= v;
  endtask : put
  task automatic rst(input logic dual, input logic pok, input drps_in_t v);
    @(posedge mclk);
    reset_n <= 0;
    drv <= v;
    cfg_dual_enable <= dual;
    cfg_power_ok_present <= pok;
    cyc(2);
    @(posedge mclk);
    reset_n <= 1;
    cyc(4);
  endtask : rst
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] msk);
    logic [2:0] got;
    got = {regulator_first, regulator_second, power_ok_out};
    cmp_count++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp & msk, got & msk);
    end
    $display("test %s done", what);
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 4000);
    num_errors++;
    close_out();
  end
  initial begin
    rst(0, 1, P | LO);
    cyc(10);
    chk("lockout at power up", 3'b000, 3'b111);
    put(P);
    cyc(10);
    chk("first before second", 3'b100, 3'b111);
    cyc(16);
    chk("second after delay", 3'b110, 3'b111);
    cyc(50);
    chk("power ok", 3'b111, 3'b111);
    for (int i = 0; i < 2; i++) begin
      put(P | (i == 0 ? LO : OT));
      cyc(6);
      chk("fault off", 3'b000, 3'b111);
      put(P);
      cyc(10);
      chk("fault restore", 3'b100, 3'b101);
      cyc(80);
      chk("fault power ok", 3'b111, 3'b111);
    end
    @(posedge mclk);
    sag <= 1;
    cyc(6);
    chk("regulation loss", 3'b100, 3'b111);
    @(posedge mclk);
    sag <= 0;
    cyc(50);
    chk("regulation back", 3'b111, 3'b111);
    put(P | SH);
    cyc(6);
    chk("short", 3'b000, 3'b010);
    put(0);
    cyc(6);
    chk("shutdown", 3'b000, 3'b111);
    rst(1, 0, S);
    cyc(6);
    chk("second alone", 3'b000, 3'b111);
    put(P);
    cyc(6);
    chk("primary alone", 3'b100, 3'b111);
    put(P | S);
    cyc(6);
    chk("dual both", 3'b110, 3'b111);
    close_out();
  end
endmodule : test_drps_top
`default_nettype wire
